// File: logic/acb_config_bank.sv
// configuration register bank behind the 16-bit serial frame interface
`timescale 1ns/1ps
module acb_config_bank (
  // clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // serial pins
  input wire logic i_sclk,
  input wire logic i_cs_b,
  input wire logic i_serial_in_line,
  output logic o_serial_out_line_first,
  output logic o_serial_out_line_second,
  output logic o_serial_out_line_third,
  output logic o_serial_out_line_fourth,
  // conversion results and flags from the converter core
  input wire logic [17:0] i_result_a,
  input wire logic [17:0] i_result_b,
  input wire logic [17:0] i_result_c,
  input wire logic [17:0] i_result_d,
  input wire logic i_out_of_range,
  input wire logic i_load_error_evt,
  // configuration outputs
  output logic [2:0] o_averaging_ratio_field,
  output logic [5:0] o_averaging_factor,
  output logic o_averaging_style_select,
  output logic o_resolution_boost,
  output logic o_power_down_select,
  output logic o_checksum_in_enable,
  output logic o_checksum_out_enable,
  output logic o_flag_on_second_line,
  output acb_pkg::acb_lane_e o_output_lane_mode,
  // events and status
  output logic o_soft_reset_pulse,
  output logic o_hard_reset_pulse,
  output logic o_frame_discard_pulse,
  output logic o_load_error
);
  import acb_pkg::*;

  function automatic logic [5:0] acb_ratio_factor(input logic [2:0] code);
    case (code)
      3'h1: return 6'h02;
      3'h2: return 6'h04;
      3'h3: return 6'h08;
      3'h4: return 6'h10;
      3'h5: return 6'h20;
      default: return 6'h00;
    endcase
  endfunction : acb_ratio_factor

  function automatic logic [6:0] acb_lane_len(input logic [2:0] words, input logic boost);
    logic [6:0] w;
    w = boost ? ACB_BOOST_RESULT_BITS : ACB_RESULT_BITS;
    return 7'(w * {4'h0, words});
  endfunction : acb_lane_len

  function automatic logic [71:0] acb_pack(input logic [17:0] a, input logic [17:0] b,
                                           input logic [17:0] c, input logic [17:0] d,
                                           input logic boost);
    if (boost) begin
      return {a, b, c, d};
    end
    return {a[15:0], b[15:0], c[15:0], d[15:0], 8'h00};
  endfunction : acb_pack

  // pin synchronisers
  logic sclk_s1, sclk_s2, sclk_s3;
  logic cs_s1, cs_s2, cs_s3;
  logic sdi_s1, sdi_s2;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
      {cs_s1, cs_s2, cs_s3} <= 3'h7;
      {sdi_s1, sdi_s2} <= 2'h0;
    end else if (i_ce) begin
      {sclk_s1, sclk_s2, sclk_s3} <= {i_sclk, sclk_s1, sclk_s2};
      {cs_s1, cs_s2, cs_s3} <= {i_cs_b, cs_s1, cs_s2};
      {sdi_s1, sdi_s2} <= {i_serial_in_line, sdi_s1};
    end
  end

  acb_frame_e frame_state;
  acb_frame_e next_frame_state;
  wire cs_fall = !cs_s2 && cs_s3;
  wire cs_rise = cs_s2 && !cs_s3;
  wire busy = (frame_state == ACB_FRAME_BUSY);
  wire frame_start = (frame_state == ACB_FRAME_IDLE) && cs_fall;
  wire frame_end = busy && cs_rise;
  wire bit_strobe = busy && !cs_s2 && sclk_s2 && !sclk_s3;
  wire shift_strobe = busy && !cs_s2 && !sclk_s2 && sclk_s3;

  always_comb begin
    case (frame_state)
      ACB_FRAME_IDLE: next_frame_state = cs_fall ? ACB_FRAME_BUSY : ACB_FRAME_IDLE;
      ACB_FRAME_BUSY: next_frame_state = cs_rise ? ACB_FRAME_IDLE : ACB_FRAME_BUSY;
      default: next_frame_state = ACB_FRAME_IDLE;
    endcase
  end

  // frame reception
  logic [23:0] rx_shift;
  logic [4:0] rx_count;
  logic rx_crc_ok;

  acb_frame_receiver u_rx (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_start(frame_start),
    .i_strobe(bit_strobe),
    .i_bit(sdi_s2),
    .o_shift(rx_shift),
    .o_count(rx_count),
    .o_crc_ok(rx_crc_ok)
  );

  // register state
  logic [11:0] setup_reg;
  acb_lane_e lane_reg;
  logic read_pending;
  logic [2:0] read_addr;
  logic load_error;

  // frame decode
  wire len_plain = (rx_count == ACB_FRAME_BITS);
  wire len_chk = (rx_count == ACB_FRAME_CRC_BITS);
  wire [15:0] rx_word = len_chk ? rx_shift[23:8] : rx_shift[15:0];
  wire rx_wr = rx_word[ACB_WR_BIT];
  wire [2:0] rx_addr = rx_word[ACB_ADDR_MSB:ACB_ADDR_LSB];
  wire [11:0] rx_data = rx_word[11:0];
  wire sets_chk_in = rx_wr && (rx_addr == ACB_ADDR_SAMPLING_SETUP) && rx_data[ACB_CHK_IN_BIT];
  wire need_chk = setup_reg[ACB_CHK_IN_BIT] || sets_chk_in;
  wire accept = (len_plain && !need_chk) || (len_chk && rx_crc_ok);
  wire frame_ok = frame_end && accept;
  wire discard = frame_end && !accept;
  wire wr_setup = frame_ok && rx_wr && (rx_addr == ACB_ADDR_SAMPLING_SETUP);
  wire wr_outctl = frame_ok && rx_wr && (rx_addr == ACB_ADDR_OUTPUT_RESET);
  wire [7:0] rst_code = rx_data[ACB_RST_MSB:ACB_RST_LSB];
  wire hard_reset = wr_outctl && (rst_code == ACB_HARD_RESET_CODE);
  wire soft_reset = wr_outctl && (rst_code == ACB_SOFT_RESET_CODE);
  wire lane_write = wr_outctl && !hard_reset && !soft_reset;
  wire valid_read_addr = (rx_addr == ACB_ADDR_SAMPLING_SETUP) ||
                         (rx_addr == ACB_ADDR_OUTPUT_RESET);
  wire read_req = frame_ok && !rx_wr && valid_read_addr;

  wire [11:0] next_setup = hard_reset ? ACB_SETUP_RESET :
                           (wr_setup ? (rx_data & ACB_SETUP_WRITE_MASK) : setup_reg);
  wire next_load_error = i_load_error_evt ? 1'b1 : (hard_reset ? 1'b0 : load_error);

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      frame_state <= ACB_FRAME_IDLE;
      setup_reg <= ACB_SETUP_RESET;
      lane_reg <= ACB_LANE_RESET;
      read_pending <= 1'b0;
      read_addr <= 3'h0;
      load_error <= 1'b0;
    end else if (i_ce) begin
      frame_state <= next_frame_state;
      setup_reg <= next_setup;
      load_error <= next_load_error;
      if (hard_reset) begin
        lane_reg <= ACB_LANE_RESET;
      end else if (lane_write) begin
        lane_reg <= acb_lane_e'(rx_data[ACB_LANE_MSB:ACB_LANE_LSB]);
      end
      if (hard_reset) begin
        read_pending <= 1'b0;
      end else if (frame_ok) begin
        read_pending <= read_req;
        read_addr <= rx_addr;
      end else if (frame_start) begin
        read_pending <= 1'b0;
      end
    end
  end

  // readback word: write flag clear, address, then data; reserved bits zero
  wire [11:0] outctl_read = {2'h0, lane_reg, 8'h00};
  wire [11:0] read_data = (read_addr == ACB_ADDR_SAMPLING_SETUP) ? setup_reg : outctl_read;
  wire [15:0] read_word = {1'b0, read_addr, read_data};

  // effective result width
  wire [5:0] factor = acb_ratio_factor(setup_reg[ACB_RATIO_MSB:ACB_RATIO_LSB]);
  wire boost = setup_reg[ACB_BOOST_BIT] && (factor != 6'h00);
  wire chk_out = setup_reg[ACB_CHK_OUT_BIT];

  // lane vectors and lengths for the coming access
  wire mode_one = (lane_reg == ACB_LANE_ONE) || (lane_reg == ACB_LANE_ONE_ALT);
  wire mode_four = (lane_reg == ACB_LANE_FOUR);
  wire mode_two = (lane_reg == ACB_LANE_TWO);
  wire [71:0] vec_one = acb_pack(i_result_a, i_result_b, i_result_c, i_result_d, boost);
  wire [71:0] vec_ab = acb_pack(i_result_a, i_result_b, 18'h00000, 18'h00000, boost);
  wire [71:0] vec_cd = acb_pack(i_result_c, i_result_d, 18'h00000, 18'h00000, boost);
  wire [71:0] vec_a = acb_pack(i_result_a, 18'h00000, 18'h00000, 18'h00000, boost);
  wire [71:0] vec_b = acb_pack(i_result_b, 18'h00000, 18'h00000, 18'h00000, boost);
  wire [71:0] vec_c = acb_pack(i_result_c, 18'h00000, 18'h00000, 18'h00000, boost);
  wire [71:0] vec_d = acb_pack(i_result_d, 18'h00000, 18'h00000, 18'h00000, boost);
  wire [2:0] words_first = mode_one ? 3'h4 : (mode_two ? 3'h2 : 3'h1);
  wire [2:0] words_second = mode_one ? 3'h0 : (mode_two ? 3'h2 : 3'h1);
  wire [2:0] words_outer = mode_four ? 3'h1 : 3'h0;

  wire [71:0] ld_vec_first = read_pending ? {read_word, 56'h0} :
                             (mode_one ? vec_one : (mode_two ? vec_ab : vec_a));
  wire [6:0] ld_len_first = read_pending ? ACB_RESULT_BITS : acb_lane_len(words_first, boost);
  wire [71:0] ld_vec_second = mode_two ? vec_cd : vec_b;
  wire [6:0] ld_len_second = read_pending ? 7'h00 : acb_lane_len(words_second, boost);
  wire [6:0] ld_len_outer = read_pending ? 7'h00 : acb_lane_len(words_outer, boost);

  logic line_first, line_second, line_third, line_fourth;

  acb_lane_shifter #(.VEC_BITS(ACB_LANE_VEC_BITS), .LEN_BITS(ACB_LEN_BITS)) u_lane_first (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_load(frame_start),
    .i_shift(shift_strobe),
    .i_vec(ld_vec_first),
    .i_len(ld_len_first),
    .i_crc_en(chk_out),
    .o_line(line_first)
  );

  acb_lane_shifter #(.VEC_BITS(ACB_LANE_VEC_BITS), .LEN_BITS(ACB_LEN_BITS)) u_lane_second (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_load(frame_start),
    .i_shift(shift_strobe),
    .i_vec(ld_vec_second),
    .i_len(ld_len_second),
    .i_crc_en(chk_out),
    .o_line(line_second)
  );

  acb_lane_shifter #(.VEC_BITS(ACB_LANE_VEC_BITS), .LEN_BITS(ACB_LEN_BITS)) u_lane_third (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_load(frame_start),
    .i_shift(shift_strobe),
    .i_vec(vec_c),
    .i_len(ld_len_outer),
    .i_crc_en(chk_out),
    .o_line(line_third)
  );

  acb_lane_shifter #(.VEC_BITS(ACB_LANE_VEC_BITS), .LEN_BITS(ACB_LEN_BITS)) u_lane_fourth (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_load(frame_start),
    .i_shift(shift_strobe),
    .i_vec(vec_d),
    .i_len(ld_len_outer),
    .i_crc_en(chk_out),
    .o_line(line_fourth)
  );

  // pin muxing; lines are low outside a frame, except the second line while it carries the out-of-range flag
  wire flag_second = (lane_reg == ACB_LANE_ONE) && setup_reg[ACB_FLAG_SEL_BIT];
  wire drive = busy && !cs_s2;
  wire next_second = flag_second ? i_out_of_range : (drive && line_second);
  wire next_fourth = mode_four && drive && line_fourth;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_serial_out_line_first <= 1'b0;
      o_serial_out_line_second <= 1'b0;
      o_serial_out_line_third <= 1'b0;
      o_serial_out_line_fourth <= 1'b0;
    end else if (i_ce) begin
      o_serial_out_line_first <= drive && line_first;
      o_serial_out_line_second <= next_second;
      o_serial_out_line_third <= drive && line_third;
      o_serial_out_line_fourth <= next_fourth;
    end
  end

  // registered configuration and event outputs
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_averaging_ratio_field <= 3'h0;
      o_averaging_factor <= 6'h00;
      o_averaging_style_select <= 1'b0;
      o_resolution_boost <= 1'b0;
      o_power_down_select <= 1'b0;
      o_checksum_in_enable <= 1'b0;
      o_checksum_out_enable <= 1'b0;
      o_flag_on_second_line <= 1'b0;
      o_output_lane_mode <= ACB_LANE_RESET;
      o_soft_reset_pulse <= 1'b0;
      o_hard_reset_pulse <= 1'b0;
      o_frame_discard_pulse <= 1'b0;
      o_load_error <= 1'b0;
    end else if (i_ce) begin
      o_averaging_ratio_field <= setup_reg[ACB_RATIO_MSB:ACB_RATIO_LSB];
      o_averaging_factor <= factor;
      o_averaging_style_select <= setup_reg[ACB_STYLE_BIT];
      o_resolution_boost <= boost;
      o_power_down_select <= setup_reg[ACB_PWRDN_BIT];
      o_checksum_in_enable <= setup_reg[ACB_CHK_IN_BIT];
      o_checksum_out_enable <= chk_out;
      o_flag_on_second_line <= flag_second;
      o_output_lane_mode <= lane_reg;
      o_soft_reset_pulse <= soft_reset;
      o_hard_reset_pulse <= hard_reset;
      o_frame_discard_pulse <= discard;
      o_load_error <= load_error;
    end
  end

endmodule : acb_config_bank

// File: logic/acb_frame_receiver.sv
// input frame shifter with running checksum
`timescale 1ns/1ps
module acb_frame_receiver (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // frame control
  input wire logic i_start,
  input wire logic i_strobe,
  input wire logic i_bit,
  // results
  output logic [23:0] o_shift,
  output logic [4:0] o_count,
  output logic o_crc_ok
);
  import acb_pkg::*;

  logic [7:0] crc;

  // checksum run over data and received checksum leaves zero when they match
  assign o_crc_ok = (crc == 8'h00);

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_shift <= 24'h000000;
      o_count <= 5'h00;
      crc <= ACB_CRC_INIT;
    end else if (i_ce) begin
      if (i_start) begin
        o_shift <= 24'h000000;
        o_count <= 5'h00;
        crc <= ACB_CRC_INIT;
      end else if (i_strobe) begin
        o_shift <= {o_shift[22:0], i_bit};
        o_count <= (o_count == 5'h1F) ? o_count : o_count + 5'h01;
        crc <= acb_crc8_step(crc, i_bit);
      end
    end
  end

endmodule : acb_frame_receiver

// File: logic/acb_lane_shifter.sv
// one serial output lane: data bits then optional checksum byte
`timescale 1ns/1ps
module acb_lane_shifter #(
  parameter int VEC_BITS = 72,
  parameter int LEN_BITS = 7
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // load and shift
  input wire logic i_load,
  input wire logic i_shift,
  input wire logic [VEC_BITS-1:0] i_vec,
  input wire logic [LEN_BITS-1:0] i_len,
  input wire logic i_crc_en,
  // line
  output logic o_line
);
  import acb_pkg::*;

  logic [VEC_BITS-1:0] sr;
  logic [LEN_BITS-1:0] left;
  logic [7:0] crc;
  logic [3:0] crc_left;
  wire data_phase = (left != '0);
  wire crc_phase = !data_phase && (crc_left != 4'h0);

  assign o_line = data_phase ? sr[VEC_BITS-1] : (crc_phase ? crc[7] : 1'b0);

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sr <= '0;
      left <= '0;
      crc <= ACB_CRC_INIT;
      crc_left <= 4'h0;
    end else if (i_ce) begin
      if (i_load) begin
        sr <= i_vec;
        left <= i_len;
        crc <= ACB_CRC_INIT;
        crc_left <= (i_crc_en && i_len != '0) ? ACB_CRC_BITS : 4'h0;
      end else if (i_shift && data_phase) begin
        crc <= acb_crc8_step(crc, sr[VEC_BITS-1]);
        sr <= {sr[VEC_BITS-2:0], 1'b0};
        left <= left - LEN_BITS'(1);
      end else if (i_shift && crc_phase) begin
        crc <= {crc[6:0], 1'b0};
        crc_left <= crc_left - 4'h1;
      end
    end
  end

endmodule : acb_lane_shifter

// File: logic/acb_pkg.sv
// shared constants, types and functions of the configuration register bank
package acb_pkg;

  // register selects carried in the frame
  localparam logic [2:0] ACB_ADDR_SAMPLING_SETUP = 3'h1;
  localparam logic [2:0] ACB_ADDR_OUTPUT_RESET = 3'h2;

  // frame layout
  localparam logic [4:0] ACB_FRAME_BITS = 5'h10;
  localparam logic [4:0] ACB_FRAME_CRC_BITS = 5'h18;
  localparam logic [3:0] ACB_CRC_BITS = 4'h8;
  localparam int ACB_WR_BIT = 15;
  localparam int ACB_ADDR_MSB = 14;
  localparam int ACB_ADDR_LSB = 12;

  // sampling_setup fields
  localparam int ACB_STYLE_BIT = 9;
  localparam int ACB_RATIO_MSB = 8;
  localparam int ACB_RATIO_LSB = 6;
  localparam int ACB_CHK_IN_BIT = 5;
  localparam int ACB_CHK_OUT_BIT = 4;
  localparam int ACB_FLAG_SEL_BIT = 3;
  localparam int ACB_BOOST_BIT = 2;
  localparam int ACB_PWRDN_BIT = 0;
  localparam logic [11:0] ACB_SETUP_WRITE_MASK = 12'h3FD;
  localparam logic [11:0] ACB_SETUP_RESET = 12'h000;

  // output_and_reset_control fields
  localparam int ACB_LANE_MSB = 9;
  localparam int ACB_LANE_LSB = 8;
  localparam int ACB_RST_MSB = 7;
  localparam int ACB_RST_LSB = 0;
  localparam logic [7:0] ACB_SOFT_RESET_CODE = 8'h3C;
  localparam logic [7:0] ACB_HARD_RESET_CODE = 8'hFF;

  // result layout
  localparam int ACB_LANE_VEC_BITS = 72;
  localparam int ACB_LEN_BITS = 7;
  localparam logic [6:0] ACB_RESULT_BITS = 7'h10;
  localparam logic [6:0] ACB_BOOST_RESULT_BITS = 7'h12;

  // checksum
  localparam logic [7:0] ACB_CRC_POLY = 8'h07;
  localparam logic [7:0] ACB_CRC_INIT = 8'h00;

  typedef enum logic [1:0] {
    ACB_LANE_TWO = 2'b00,
    ACB_LANE_ONE = 2'b01,
    ACB_LANE_FOUR = 2'b10,
    ACB_LANE_ONE_ALT = 2'b11
  } acb_lane_e;

  localparam acb_lane_e ACB_LANE_RESET = ACB_LANE_TWO;

  typedef enum logic {
    ACB_FRAME_IDLE = 1'b0,
    ACB_FRAME_BUSY = 1'b1
  } acb_frame_e;

  function automatic logic [7:0] acb_crc8_step(input logic [7:0] crc, input logic bit_in);
    logic fb;
    fb = crc[7] ^ bit_in;
    return {crc[6:0], 1'b0} ^ (fb ? ACB_CRC_POLY : 8'h00);
  endfunction : acb_crc8_step

endpackage : acb_pkg

// File: tb/acb_config_bank_asserts.sv
// port-level assertions for the configuration register bank
`timescale 1ns/1ps
module acb_config_bank_asserts (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // watched outputs
  input wire logic o_serial_out_line_third,
  input wire logic o_serial_out_line_fourth,
  input wire logic [2:0] o_averaging_ratio_field,
  input wire logic [5:0] o_averaging_factor,
  input wire logic o_averaging_style_select,
  input wire logic o_resolution_boost,
  input wire logic o_power_down_select,
  input wire logic o_checksum_in_enable,
  input wire logic o_checksum_out_enable,
  input wire logic o_flag_on_second_line,
  input wire acb_pkg::acb_lane_e o_output_lane_mode,
  input wire logic o_soft_reset_pulse,
  input wire logic o_hard_reset_pulse,
  input wire logic o_frame_discard_pulse,
  input wire logic o_load_error
);
  import acb_pkg::*;
  wire logic [10:0] cfg = {o_averaging_ratio_field, o_averaging_style_select, o_resolution_boost,
    o_power_down_select, o_checksum_in_enable, o_checksum_out_enable, o_flag_on_second_line,
    o_output_lane_mode};
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_b);
  a_factor_decode: assert property (o_averaging_factor == ((o_averaging_ratio_field == 3'h0 ||
    o_averaging_ratio_field > 3'h5) ? 6'h00 : 6'h01 << o_averaging_ratio_field))
    else $error("averaging factor does not match ratio field");
  a_boost_needs_ratio: assert property (o_resolution_boost |-> o_averaging_factor != 6'h00)
    else $error("boost active without averaging");
  a_flag_one_lane: assert property (o_flag_on_second_line |->
    (o_output_lane_mode == ACB_LANE_ONE))
    else $error("flag routed outside one-lane mode");
  a_fourth_line_quiet: assert property ((o_output_lane_mode != ACB_LANE_FOUR &&
    $past(o_output_lane_mode) != ACB_LANE_FOUR) |-> !o_serial_out_line_fourth)
    else $error("fourth line active outside four-lane mode");
  a_third_line_quiet: assert property ((o_output_lane_mode != ACB_LANE_FOUR &&
    $past(o_output_lane_mode) != ACB_LANE_FOUR) |-> !o_serial_out_line_third)
    else $error("third line active outside four-lane mode");
  a_soft_single_pulse: assert property (o_soft_reset_pulse |=> !o_soft_reset_pulse)
    else $error("soft reset pulse longer than one cycle");
  a_soft_keeps_cfg: assert property (o_soft_reset_pulse |-> $stable(cfg) ##1 $stable(cfg))
    else $error("soft reset changed configuration");
  a_hard_defaults: assert property (o_hard_reset_pulse |-> ##[0:1] (cfg == 11'h000))
    else $error("hard reset left configuration non-default");
  a_discard_keeps_cfg: assert property (o_frame_discard_pulse |->
    $stable(cfg) ##1 $stable(cfg))
    else $error("discarded frame changed configuration");
  a_load_error_sticky: assert property ($fell(o_load_error) |->
    (o_hard_reset_pulse || $past(o_hard_reset_pulse)))
    else $error("load error cleared without hard reset");
endmodule : acb_config_bank_asserts

bind acb_config_bank acb_config_bank_asserts acb_config_bank_asserts_i (
  .i_mclk, .i_rst_b, .o_serial_out_line_third, .o_serial_out_line_fourth,
  .o_averaging_ratio_field, .o_averaging_factor, .o_averaging_style_select,
  .o_resolution_boost, .o_power_down_select, .o_checksum_in_enable, .o_checksum_out_enable,
  .o_flag_on_second_line, .o_output_lane_mode, .o_soft_reset_pulse, .o_hard_reset_pulse,
  .o_frame_discard_pulse, .o_load_error
);

// File: tb/acb_config_bank_test.sv
// self-checking testbench for the configuration register bank
`timescale 1ns/1ps
module acb_config_bank_test;
  import acb_pkg::*;
  logic mclk, rst_b, ce, sclk, cs_b, serial_in_line, oor, lerr_evt;
  logic [17:0] res_a, res_b, res_c, res_d;
  logic [3:0] lines;
  logic [2:0] ratio;
  logic [5:0] factor;
  logic style, boost, pwrdn, chk_in, chk_out, flag2, soft_p, hard_p, disc_p, load_err;
  acb_lane_e lane;
  int fail_count = 0, checks = 0, soft_n = 0, hard_n = 0, disc_n = 0;
  acb_config_bank acb_config_bank_i (
    .i_mclk(mclk), .i_rst_b(rst_b), .i_ce(ce), .i_sclk(sclk), .i_cs_b(cs_b),
    .i_serial_in_line(serial_in_line), .o_serial_out_line_first(lines[0]),
    .o_serial_out_line_second(lines[1]), .o_serial_out_line_third(lines[2]),
    .o_serial_out_line_fourth(lines[3]), .i_result_a(res_a), .i_result_b(res_b),
    .i_result_c(res_c), .i_result_d(res_d), .i_out_of_range(oor), .i_load_error_evt(lerr_evt),
    .o_averaging_ratio_field(ratio), .o_averaging_factor(factor),
    .o_averaging_style_select(style), .o_resolution_boost(boost), .o_power_down_select(pwrdn),
    .o_checksum_in_enable(chk_in), .o_checksum_out_enable(chk_out),
    .o_flag_on_second_line(flag2), .o_output_lane_mode(lane), .o_soft_reset_pulse(soft_p),
    .o_hard_reset_pulse(hard_p), .o_frame_discard_pulse(disc_p), .o_load_error(load_err)
  );
  acb_host acb_host_i (.i_mclk(mclk), .o_sclk(sclk), .o_cs_b(cs_b), .o_sdi(serial_in_line), .i_lines(lines));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (soft_p === 1'b1) soft_n++;
    if (hard_p === 1'b1) hard_n++;
    if (disc_p === 1'b1) disc_n++;
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic fr(input logic [15:0] w, input int mode);
    acb_host_i.frame(w, mode);
  endtask : fr
  // read request, then a filler frame that carries the answer
  task automatic rd(input logic [2:0] a, input int mode);
    fr({1'b0, a, 12'h000}, 0);
    fr(16'h0000, mode);
  endtask : rd
  task automatic t_defaults();
    check({ratio, style, boost, pwrdn, chk_in, chk_out, flag2, lane, load_err}, 0, "reset");
    rd(3'h1, 0);
    check(acb_host_i.rx[0][15:0], 16'h1000, "setup readback");
    rd(3'h2, 0);
    check(acb_host_i.rx[0][15:0], 16'h2000, "control readback");
    $display("test defaults done");
  endtask : t_defaults
  task automatic t_reserved();
    fr(16'h9FDF, 0);
    check({style, ratio, factor, boost, chk_out, flag2, pwrdn}, 14'h3C05, "fields");
    rd(3'h1, 1);
    check(acb_host_i.rx[0], {16'h13DD, acb_host_i.crc8(16'h13DD)}, "checksum on");
    fr(16'h9000, 0);
    rd(3'h1, 1);
    check(acb_host_i.rx[0], 24'h100000, "checksum off");
    $display("test reserved done");
  endtask : t_reserved
  task automatic t_ratio();
    for (int c = 0; c < 8; c++) begin
      logic [5:0] f;
      f = (c == 0 || c > 5) ? 6'h00 : 6'(1 << c);
      fr(16'h9004 | 16'(c << 6), 0);
      check({ratio, factor, boost}, {3'(c), f, f != 6'h00}, "ratio code");
    end
    $display("test ratio done");
  endtask : t_ratio
  task automatic t_crc_in();
    int d;
    d = disc_n;
    fr(16'h9020, 0);
    check(chk_in, 1'b0, "set without checksum");
    fr(16'h9020, 2);
    check(chk_in, 1'b0, "set with bad checksum");
    fr(16'h9020, 1);
    check(chk_in, 1'b1, "set with checksum");
    fr(16'h9041, 0);
    check({chk_in, ratio, pwrdn}, 5'h10, "unchecked write");
    fr(16'h9000, 1);
    check(chk_in, 1'b0, "clear with checksum");
    check(24'(disc_n - d), 24'h000003, "discards");
    $display("test checksum in done");
  endtask : t_crc_in
  task automatic lane_chk(input logic [1:0] m, input logic [63:0] e, input logic ef);
    fr({4'hA, 2'b00, m, 8'h00}, 0);
    check({lane, flag2}, {m, ef}, "lane mode");
    fr(16'h0000, 0);
    for (int k = 0; k < 4; k++) check(acb_host_i.rx[k][15:0], e[63-16*k -: 16], "lane");
  endtask : lane_chk
  task automatic t_lanes();
    @(posedge mclk);
    res_a <= 18'h3A5C3;
    res_b <= 18'h31234;
    res_c <= 18'h35678;
    res_d <= 18'h39ABC;
    oor <= 1'b1;
    fr(16'h9008, 0);
    lane_chk(2'b00, 64'hA5C3_5678_0000_0000, 1'b0);
    lane_chk(2'b10, 64'hA5C3_1234_5678_9ABC, 1'b0);
    lane_chk(2'b01, 64'hA5C3_FFFF_0000_0000, 1'b1);
    lane_chk(2'b11, 64'hA5C3_0000_0000_0000, 1'b0);
    $display("test lanes done");
  endtask : t_lanes
  task automatic t_resets();
    int s;
    int h;
    @(posedge mclk);
    lerr_evt <= 1'b1;
    @(posedge mclk);
    lerr_evt <= 1'b0;
    fr(16'h9041, 0);
    fr(16'hA200, 0);
    s = soft_n;
    h = hard_n;
    fr(16'hA03C, 0);
    check(24'(soft_n - s), 24'h000001, "soft pulse");
    check({ratio, pwrdn, lane, load_err}, 7'h1D, "soft keeps");
    fr(16'hA155, 0);
    check({lane, load_err, 24'(soft_n - s + hard_n - h)}, {3'h3, 24'h000001}, "other code");
    fr(16'hA0FF, 0);
    check(24'(hard_n - h), 24'h000001, "hard pulse");
    check({ratio, pwrdn, lane, load_err, flag2}, 0, "hard defaults");
    $display("test resets done");
  endtask : t_resets
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    oor = 1'b0;
    lerr_evt = 1'b0;
    res_a = 18'h00000;
    res_b = 18'h00000;
    res_c = 18'h00000;
    res_d = 18'h00000;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    t_defaults();
    t_reserved();
    t_ratio();
    t_crc_in();
    t_lanes();
    t_resets();
    wrap_up();
  end
  initial begin
    #150000;
    fail_count++;
    wrap_up();
  end
endmodule : acb_config_bank_test

// File: tb/acb_host.sv
// host serial port model: sends frames and captures the four output lines
`timescale 1ns/1ps
module acb_host (
  // clock
  input wire logic i_mclk,
  // pins toward the device
  output logic o_sclk,
  output logic o_cs_b,
  output logic o_sdi,
  // lines from the device
  input wire logic [3:0] i_lines
);
  import acb_pkg::*;
  logic [23:0] rx [4];
  initial begin
    o_sclk = 1'b0;
    o_cs_b = 1'b1;
    o_sdi = 1'b0;
  end
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = ACB_CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ ACB_CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc8
  // mode 0: bare word, 1: checksum appended, 2: corrupted checksum
  task automatic frame(input logic [15:0] w, input int mode);
    logic [23:0] word;
    int n;
    word = {w, crc8(w) ^ ((mode == 2) ? 8'h01 : 8'h00)};
    n = (mode != 0) ? 24 : 16;
    for (int k = 0; k < 4; k++) rx[k] = 24'h000000;
    @(posedge i_mclk);
    o_cs_b <= 1'b0;
    repeat (4) @(posedge i_mclk);
    for (int i = 23; i >= 24 - n; i--) begin
      o_sdi <= word[i];
      repeat (4) @(posedge i_mclk);
      o_sclk <= 1'b1;
      repeat (4) @(posedge i_mclk);
      for (int k = 0; k < 4; k++) rx[k] = {rx[k][22:0], i_lines[k]};
      o_sclk <= 1'b0;
    end
    repeat (4) @(posedge i_mclk);
    o_cs_b <= 1'b1;
    // released line shows the inverse so a stale bit cannot pass
    o_sdi <= ~word[24 - n];
    repeat (10) @(posedge i_mclk);
  endtask : frame
endmodule : acb_host
